// File: trc_pkg.sv
// constants and register map of the transfer request checker
package trc_pkg;
   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ADR_CODE = 8'h00;
   localparam logic [7:0] ADR_COUNT = 8'h04;
   localparam logic [7:0] ADR_UNIT = 8'h08;
   localparam logic [7:0] ADR_INDIR = 8'h0c;
   localparam logic [7:0] ADR_GO = 8'h10;
   localparam logic [7:0] ADR_FLAGS = 8'h14;
   localparam logic [7:0] ADR_ISTAT = 8'h18;
   localparam logic [7:0] ADR_IMASK = 8'h1c;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int UNIT_REMOTE_BIT = 7;
   localparam int INDIR_USE_BIT = 16;
   localparam int GO_READ_BIT = 0;
   localparam int GO_WRITE_BIT = 1;
   localparam int FLG_EXEC = 0;
   localparam int FLG_RDOK = 1;
   localparam int FLG_XERR = 2;
   localparam int FLG_BUSY = 3;
   localparam int FLG_CNT_LSB = 8;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_EXEC = 1;
   localparam int IRQ_XERR = 2;
   // -----------------------------------------------------------------
   // codes, limits and reset values
   // -----------------------------------------------------------------
   localparam logic [3:0] CODE_VAR1 = 4'ha;
   localparam logic [3:0] CODE_VAR3 = 4'hb;
   localparam logic [3:0] CODE_TBL = 4'hc;
   localparam logic [15:0] CODE_CLR = 16'hec00;
   localparam logic [13:0] MAX_WORDS = 14'h0080;
   localparam logic [13:0] MEM_MAX = 14'h1a00;
   localparam logic [13:0] UNIT_MAX = 14'h000f;
   localparam logic [13:0] VAR_END = 14'h00fb;
   localparam logic [13:0] TBL_END = 14'h0640;
   localparam logic [13:0] TBL_FACTOR = 14'h000a;
   localparam logic [13:0] ITEM_WORDS = 14'h0003;
   localparam logic [13:0] ONE_WORD = 14'h0001;
   localparam logic [2:0] IRQ_RST = 3'h0;
   localparam logic [15:0] REQ_RST = 16'h0000;
endpackage : trc_pkg

// File: trc_checker.sv
// transfer request checker: wishbone slave, request evaluation, status flags
//
// Implementation choices: the Wishbone slave port and the register addresses.
module trc_checker #(
   parameter int CAP = 4,
   parameter int CNT_W = 4
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic unitCmdReq,
   input wire logic xferDone,
   output logic execErrorFlag,
   output logic readOkFlag,
   output logic xferErrorFlag,
   output logic irq
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {trcIdle, trcDecode, trcJudge} trc_state_e;

   typedef struct packed {
      trc_state_e st;
      logic ack;
      logic [31:0] dat;
      logic [15:0] code;
      logic [15:0] count;
      logic [7:0] unit;
      logic [16:0] indir;
      logic isRead;
      logic cntBad;
      logic memBad;
      logic unitBad;
      logic [13:0] cntBin;
      logic [13:0] startBin;
      logic execErr;
      logic readOk;
      logic xferErr;
      logic [CNT_W-1:0] inflight;
      logic [2:0] istat;
      logic [2:0] imask;
      logic irq;
   } trc_state_s;

   trc_state_s s_r, s_nxt;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // every nibble must be a decimal digit
   function automatic logic isBcd(input logic [15:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (v[4*i+:4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // four bcd digits to binary, caller checks validity first
   function automatic logic [13:0] bcdVal(input logic [15:0] v);
      return 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100 + 14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
   endfunction

   // byte lane merge for narrow registers
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i+:8] = nw[8*i+:8];
         end
      end
      return r;
   endfunction

   // -----------------------------------------------------------------
   // combinational view of the request under judgement
   // -----------------------------------------------------------------
   logic take, doWr, doRd, goHit, judge, full, codeBad, threeWord, rangeBad, isClr, ovfUnit, ovfCpu;
   logic [13:0] items, endIdx;
   logic [31:0] wv;
   logic execNow, xerrNow, startCpu;

   assign take = wb_cyc_i && wb_stb_i && !s_r.ack;
   assign doWr = take && wb_we_i;
   assign doRd = take && !wb_we_i;
   assign goHit = doWr && wb_adr_i == trc_pkg::ADR_GO && wb_sel_i[0];
   assign judge = s_r.st == trcJudge;
   assign full = 32'(s_r.inflight) >= CAP;
   assign wv = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);

   // classify the control code and the range it asks for
   always_comb begin
      isClr = s_r.code == trc_pkg::CODE_CLR;
      threeWord = s_r.code[15:12] == trc_pkg::CODE_VAR3 || s_r.code[15:12] == trc_pkg::CODE_TBL;
      codeBad = 1'b0;
      rangeBad = 1'b0;
      items = threeWord ? s_r.cntBin / trc_pkg::ITEM_WORDS : s_r.cntBin;
      endIdx = s_r.startBin + items;
      if (isClr) begin
         codeBad = s_r.cntBin != trc_pkg::ONE_WORD;
      end else if (s_r.code[15:12] == trc_pkg::CODE_VAR1 || s_r.code[15:12] == trc_pkg::CODE_VAR3) begin
         codeBad = !isBcd({4'h0, s_r.code[11:0]});
         rangeBad = endIdx > trc_pkg::VAR_END;
      end else if (s_r.code[15:12] == trc_pkg::CODE_TBL) begin
         codeBad = !isBcd({4'h0, s_r.code[11:0]});
         endIdx = s_r.startBin * trc_pkg::TBL_FACTOR + items;
         rangeBad = endIdx > trc_pkg::TBL_END;
      end else begin
         codeBad = 1'b1;
      end
      // item data itself is passed on unchecked; the requester keeps it legal
   end

   // overflow of shared transfer capacity, cpu or unit side
   assign ovfUnit = unitCmdReq && full;
   assign ovfCpu = judge && !isClr && full;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [31:0] mrg;
      mrg = 32'h0000_0000;
      s_nxt = s_r;
      execNow = s_r.cntBad || s_r.memBad || s_r.unitBad;
      xerrNow = !execNow && (codeBad || (threeWord && !isClr && s_r.cntBin % trc_pkg::ITEM_WORDS != 14'h0)
                 || (!isClr && rangeBad) || ovfCpu);
      startCpu = judge && !execNow && !xerrNow && !isClr;
      // bus slave: answer one cycle after the request, drop ack next cycle
      s_nxt.ack = take;
      if (take) begin
         s_nxt.dat = 32'h0000_0000;
      end
      if (doWr) begin
         if (wb_adr_i == trc_pkg::ADR_CODE) begin
            mrg = laneMerge({16'h0000, s_r.code}, wb_dat_i, wb_sel_i);
            s_nxt.code = mrg[15:0];
         end else if (wb_adr_i == trc_pkg::ADR_COUNT) begin
            mrg = laneMerge({16'h0000, s_r.count}, wb_dat_i, wb_sel_i);
            s_nxt.count = mrg[15:0];
         end else if (wb_adr_i == trc_pkg::ADR_UNIT) begin
            mrg = laneMerge({24'h0, s_r.unit}, wb_dat_i, wb_sel_i);
            s_nxt.unit = mrg[7:0];
         end else if (wb_adr_i == trc_pkg::ADR_INDIR) begin
            mrg = laneMerge({15'h0, s_r.indir}, wb_dat_i, wb_sel_i);
            s_nxt.indir = mrg[16:0];
         end else if (wb_adr_i == trc_pkg::ADR_IMASK) begin
            mrg = laneMerge({29'h0, s_r.imask}, wb_dat_i, wb_sel_i);
            s_nxt.imask = mrg[2:0];
         end
      end
      if (doRd) begin
         if (wb_adr_i == trc_pkg::ADR_CODE) begin
            s_nxt.dat = {16'h0000, s_r.code};
         end else if (wb_adr_i == trc_pkg::ADR_COUNT) begin
            s_nxt.dat = {16'h0000, s_r.count};
         end else if (wb_adr_i == trc_pkg::ADR_UNIT) begin
            s_nxt.dat = {24'h0, s_r.unit};
         end else if (wb_adr_i == trc_pkg::ADR_INDIR) begin
            s_nxt.dat = {15'h0, s_r.indir};
         end else if (wb_adr_i == trc_pkg::ADR_FLAGS) begin
            s_nxt.dat[trc_pkg::FLG_EXEC] = s_r.execErr;
            s_nxt.dat[trc_pkg::FLG_RDOK] = s_r.readOk;
            s_nxt.dat[trc_pkg::FLG_XERR] = s_r.xferErr;
            s_nxt.dat[trc_pkg::FLG_BUSY] = s_r.st != trcIdle;
            s_nxt.dat[trc_pkg::FLG_CNT_LSB+:CNT_W] = s_r.inflight;
         end else if (wb_adr_i == trc_pkg::ADR_ISTAT) begin
            s_nxt.dat = {29'h0, s_r.istat};
            s_nxt.istat = 3'h0; // read clears; new events below still win
         end else if (wb_adr_i == trc_pkg::ADR_IMASK) begin
            s_nxt.dat = {29'h0, s_r.imask};
         end
      end
      // evaluation sequence; a go while busy is ignored
      case (s_r.st)
         trcIdle: begin
            if (goHit && (wv[trc_pkg::GO_READ_BIT] || wv[trc_pkg::GO_WRITE_BIT])) begin
               s_nxt.isRead = wv[trc_pkg::GO_READ_BIT];
               s_nxt.st = trcDecode;
            end
         end
         trcDecode: begin
            s_nxt.cntBin = bcdVal(s_r.count);
            s_nxt.startBin = bcdVal({4'h0, s_r.code[11:0]});
            s_nxt.cntBad = !isBcd(s_r.count) || s_r.count == 16'h0000
                           || bcdVal(s_r.count) > trc_pkg::MAX_WORDS;
            s_nxt.memBad = s_r.indir[trc_pkg::INDIR_USE_BIT] && (!isBcd(s_r.indir[15:0])
                           || bcdVal(s_r.indir[15:0]) > trc_pkg::MEM_MAX);
            s_nxt.unitBad = 14'(s_r.unit[6:0]) > trc_pkg::UNIT_MAX
                            || s_r.unit[trc_pkg::UNIT_REMOTE_BIT];
            s_nxt.st = trcJudge;
         end
         trcJudge: begin
            // exec error and read ok change only in this step and hold until the next judge; transfer error also sets on unit overflow
            s_nxt.execErr = execNow;
            s_nxt.readOk = s_r.isRead && !execNow && !xerrNow;
            s_nxt.st = trcIdle;
         end
         default: begin
            s_nxt.st = trcIdle;
         end
      endcase
      // transfer error: sticky until the clear code, set beats clear
      if (judge && !execNow && isClr && !codeBad) begin
         s_nxt.xferErr = 1'b0;
      end
      if ((judge && xerrNow) || ovfUnit) begin
         s_nxt.xferErr = 1'b1;
      end
      // shared capacity counter of transfers in flight
      s_nxt.inflight = s_r.inflight + CNT_W'(startCpu) + CNT_W'(unitCmdReq && !full)
                       - CNT_W'(xferDone && s_r.inflight != '0);
      // sticky interrupt sources
      if (judge) begin
         s_nxt.istat[trc_pkg::IRQ_DONE] = 1'b1;
      end
      if (judge && execNow) begin
         s_nxt.istat[trc_pkg::IRQ_EXEC] = 1'b1;
      end
      if ((judge && xerrNow) || ovfUnit) begin
         s_nxt.istat[trc_pkg::IRQ_XERR] = 1'b1;
      end
      s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   // clock enable low freezes everything, the bus answer included
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
         s_r.st <= trcIdle;
         s_r.code <= trc_pkg::REQ_RST;
         s_r.count <= trc_pkg::REQ_RST;
         s_r.istat <= trc_pkg::IRQ_RST;
         s_r.imask <= trc_pkg::IRQ_RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;
   assign execErrorFlag = s_r.execErr;
   assign readOkFlag = s_r.readOk;
   assign xferErrorFlag = s_r.xferErr;
   assign irq = s_r.irq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_cntErr;
      @(posedge sys_clk) disable iff (!nrst) ce && judge && s_r.cntBad |=> execErrorFlag;
   endproperty
   a_cntErr: assert property (p_cntErr) else $error("bad count did not raise exec error");

   property p_memErr;
      @(posedge sys_clk) disable iff (!nrst) ce && judge && s_r.memBad |=> execErrorFlag && !readOkFlag;
   endproperty
   a_memErr: assert property (p_memErr) else $error("bad indirect address missed");

   property p_unitErr;
      @(posedge sys_clk) disable iff (!nrst)
         ce && s_r.st == trcDecode && s_r.unit[trc_pkg::UNIT_REMOTE_BIT] ##1 ce [*2] |=> execErrorFlag;
   endproperty
   a_unitErr: assert property (p_unitErr) else $error("remote unit not flagged");

   property p_execClr;
      @(posedge sys_clk) disable iff (!nrst)
         ce && judge && !s_r.cntBad && !s_r.memBad && !s_r.unitBad |=> !execErrorFlag;
   endproperty
   a_execClr: assert property (p_execClr) else $error("exec error not cleared");

   // a sticky transfer error from an earlier request must not spoil a clean read
   property p_readOk;
      @(posedge sys_clk) disable iff (!nrst)
         ce && judge |=> readOkFlag == ($past(s_r.isRead) && !execErrorFlag && !$past(xerrNow));
   endproperty
   a_readOk: assert property (p_readOk) else $error("read ok does not match the outcome");

   property p_badCode;
      @(posedge sys_clk) disable iff (!nrst)
         ce && judge && codeBad && !s_r.execErr && !s_r.cntBad && !s_r.memBad && !s_r.unitBad
         |=> xferErrorFlag && !readOkFlag;
   endproperty
   a_badCode: assert property (p_badCode) else $error("unsupported code not flagged");

   property p_notThree;
      @(posedge sys_clk) disable iff (!nrst)
         ce && judge && threeWord && !isClr && s_r.cntBin % trc_pkg::ITEM_WORDS != 14'd0
         && !s_r.cntBad && !s_r.memBad && !s_r.unitBad |=> xferErrorFlag;
   endproperty
   a_notThree: assert property (p_notThree) else $error("count not multiple of three missed");

   property p_ovf;
      @(posedge sys_clk) disable iff (!nrst) ce && unitCmdReq && full |=> xferErrorFlag;
   endproperty
   a_ovf: assert property (p_ovf) else $error("capacity overflow not flagged");

   property p_xerrCause;
      @(posedge sys_clk) disable iff (!nrst) $rose(xferErrorFlag) |-> $past(judge || unitCmdReq);
   endproperty
   a_xerrCause: assert property (p_xerrCause) else $error("transfer error rose without cause");

   property p_hold;
      @(posedge sys_clk) disable iff (!nrst) !(ce && judge) |=> $stable(execErrorFlag) && $stable(readOkFlag);
   endproperty
   a_hold: assert property (p_hold) else $error("flags moved outside evaluation");

   property p_range;
      @(posedge sys_clk) disable iff (!nrst)
         ce && judge && !execNow && !isClr && rangeBad |=> xferErrorFlag;
   endproperty
   a_range: assert property (p_range) else $error("out of range transfer not flagged");

   property p_clrOk;
      @(posedge sys_clk) disable iff (!nrst)
         ce && judge && !execNow && isClr && s_r.cntBin == trc_pkg::ONE_WORD && !ovfUnit |=> !xferErrorFlag;
   endproperty
   a_clrOk: assert property (p_clrOk) else $error("clear code left transfer error set");

   property p_clrBad;
      @(posedge sys_clk) disable iff (!nrst)
         ce && judge && !execNow && isClr && s_r.cntBin != trc_pkg::ONE_WORD |=> xferErrorFlag;
   endproperty
   a_clrBad: assert property (p_clrBad) else $error("clear code with wrong amount accepted");

   // a stalled clock enable must not let any state move, flags included
   property p_freeze;
      @(posedge sys_clk) disable iff (!nrst) !ce |=> $stable(s_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

   property p_ackPulse;
      @(posedge sys_clk) disable iff (!nrst) ce && wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("bus answer longer than one cycle");
endmodule // trc_checker

// File: trc_unit_model.sv
// unit-side partner: turns bench kicks into registered command and completion pulses
module trc_unit_model (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cmdKick,
   input wire logic doneKick,
   output logic unitCmdReq,
   output logic xferDone
);
   timeunit 1ns;
   timeprecision 1ps;
   // registered copy of each kick, one cycle later and as long as the kick, as the unit logic would give it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         unitCmdReq <= 1'b0;
         xferDone <= 1'b0;
      end else begin
         unitCmdReq <= cmdKick;
         xferDone <= doneKick;
      end
   end
endmodule // trc_unit_model

// File: tb.sv
// self-checking testbench of the transfer request checker
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, nrst = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbDat = 32'h0, wbDatO, rdv;
   logic wbAck, cmdKick = 1'b0, doneKick = 1'b0, unitCmdReq, xferDone;
   logic ce = 1'b1;
   logic execErrorFlag, readOkFlag, xferErrorFlag, irq;
   int mismatches = 0, testsRun = 0;
   // ---------------------------------------------------------------
   // instances
   // ---------------------------------------------------------------
   trc_checker #(.CAP(4), .CNT_W(4)) uut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .unitCmdReq(unitCmdReq), .xferDone(xferDone),
      .execErrorFlag(execErrorFlag), .readOkFlag(readOkFlag), .xferErrorFlag(xferErrorFlag), .irq(irq));
   trc_unit_model partner (.sys_clk(sys_clk), .nrst(nrst), .cmdKick(cmdKick), .doneKick(doneKick),
      .unitCmdReq(unitCmdReq), .xferDone(xferDone));
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic stopTest();
      $display("mismatches %0d tests_run %0d", mismatches, testsRun);
      if (mismatches == 0 && testsRun > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (exp !== got) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // classic cycle: hold everything until ack is sampled, release at that edge
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge sys_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDat <= dat;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 40);
      rdv = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      if (n >= 40) begin
         mismatches++;
         stopTest();
      end
   endtask
   // one pulse towards the unit-side model
   task automatic kick(input bit done);
      @(posedge sys_clk);
      if (done) doneKick <= 1'b1;
      else cmdKick <= 1'b1;
      @(posedge sys_clk);
      doneKick <= 1'b0;
      cmdKick <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   // program one request, start it, wait for busy to fall, judge {xerr, readok, exec}
   task automatic ev(input logic [15:0] c, input logic [15:0] n, input logic [7:0] u, input logic [16:0] d,
                     input logic rd, input logic [2:0] exp);
      int k;
      wb(1'b1, trc_pkg::ADR_CODE, {16'h0, c});
      wb(1'b1, trc_pkg::ADR_COUNT, {16'h0, n});
      wb(1'b1, trc_pkg::ADR_UNIT, {24'h0, u});
      wb(1'b1, trc_pkg::ADR_INDIR, {15'h0, d});
      wb(1'b1, trc_pkg::ADR_GO, rd ? 32'h1 : 32'h2);
      k = 0;
      do begin
         wb(1'b0, trc_pkg::ADR_FLAGS, 32'h0);
         k++;
      end while (rdv[trc_pkg::FLG_BUSY] !== 1'b0 && k < 20);
      // an evaluation that never ends is a failure, not a silent pass
      if (rdv[trc_pkg::FLG_BUSY] !== 1'b0) begin
         mismatches++;
         stopTest();
      end
      chk("flags", {29'h0, exp}, {29'h0, xferErrorFlag, readOkFlag, execErrorFlag});
      // a clean transfer holds a capacity slot; let the unit finish it
      if (exp[0] === 1'b0 && exp[2] === 1'b0 && c !== trc_pkg::CODE_CLR) kick(1'b1);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic testReset();
      chk("outputs at reset", 32'h0, {28'h0, execErrorFlag, readOkFlag, xferErrorFlag, irq});
      wb(1'b0, trc_pkg::ADR_FLAGS, 32'h0);
      chk("flags reg", 32'h0, rdv);
      wb(1'b0, trc_pkg::ADR_IMASK, 32'h0);
      chk("imask", {29'h0, trc_pkg::IRQ_RST}, rdv);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", 32'h0, rdv);
   endtask
   task automatic testExec();
      ev(16'ha123, 16'h0020, 8'h00, 17'h0, 1'b1, 3'b010);
      ev(16'ha000, 16'h0000, 8'h00, 17'h0, 1'b1, 3'b001);
      ev(16'ha000, 16'h0129, 8'h00, 17'h0, 1'b1, 3'b001);
      ev(16'ha000, 16'h001a, 8'h00, 17'h0, 1'b1, 3'b001);
      ev(16'ha000, 16'h0128, 8'h00, 17'h0, 1'b1, 3'b010);
      ev(16'ha000, 16'h0001, 8'h00, 17'h16657, 1'b1, 3'b001);
      ev(16'ha000, 16'h0001, 8'h00, 17'h12a40, 1'b1, 3'b001);
      ev(16'ha000, 16'h0001, 8'h0f, 17'h16656, 1'b1, 3'b010);
      ev(16'ha000, 16'h0001, 8'h10, 17'h0, 1'b1, 3'b001);
      ev(16'ha000, 16'h0001, 8'h8f, 17'h0, 1'b1, 3'b001);
      ev(16'ha000, 16'h0001, 8'h00, 17'h0, 1'b0, 3'b000);
   endtask
   task automatic testXfer();
      ev(16'hd000, 16'h0003, 8'h00, 17'h0, 1'b1, 3'b100);
      ev(trc_pkg::CODE_CLR, 16'h0001, 8'h00, 17'h0, 1'b0, 3'b000);
      ev(16'hb000, 16'h0010, 8'h00, 17'h0, 1'b1, 3'b100);
      ev(trc_pkg::CODE_CLR, 16'h0002, 8'h00, 17'h0, 1'b0, 3'b100);
      ev(trc_pkg::CODE_CLR, 16'h0001, 8'h00, 17'h0, 1'b0, 3'b000);
      ev(16'hb246, 16'h0012, 8'h00, 17'h0, 1'b1, 3'b010);
      ev(16'ha250, 16'h0001, 8'h00, 17'h0, 1'b1, 3'b010);
      ev(16'ha251, 16'h0001, 8'h00, 17'h0, 1'b1, 3'b100);
      ev(trc_pkg::CODE_CLR, 16'h0001, 8'h00, 17'h0, 1'b0, 3'b000);
      ev(16'hc160, 16'h0003, 8'h00, 17'h0, 1'b0, 3'b100);
      ev(16'hd000, 16'h0000, 8'h00, 17'h0, 1'b1, 3'b101);
      ev(trc_pkg::CODE_CLR, 16'h0001, 8'h00, 17'h0, 1'b0, 3'b000);
   endtask
   task automatic testCapacity();
      repeat (4) kick(1'b0);
      wb(1'b0, trc_pkg::ADR_FLAGS, 32'h0);
      chk("slots", 32'h00000400, rdv);
      kick(1'b0);
      chk("overflow", 32'h1, {31'h0, xferErrorFlag});
      repeat (4) kick(1'b1);
      ev(trc_pkg::CODE_CLR, 16'h0001, 8'h00, 17'h0, 1'b0, 3'b000);
   endtask
   // stall the clock enable in the judge step: flags must hold, then update once it returns
   task automatic testFreeze();
      wb(1'b0, trc_pkg::ADR_CODE, 32'h0);
      chk("code readback", {16'h0, trc_pkg::CODE_CLR}, rdv);
      wb(1'b1, trc_pkg::ADR_COUNT, 32'h0);
      wb(1'b1, trc_pkg::ADR_GO, 32'h1);
      ce <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("exec while frozen", 32'h0, {31'h0, execErrorFlag});
      ce <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("exec after thaw", 32'h1, {31'h0, execErrorFlag});
   endtask
   task automatic testIrq();
      wb(1'b1, trc_pkg::ADR_IMASK, 32'h7);
      wb(1'b0, trc_pkg::ADR_ISTAT, 32'h0);
      ev(16'ha000, 16'h0000, 8'h00, 17'h0, 1'b1, 3'b001);
      chk("irq raised", 32'h1, {31'h0, irq});
      wb(1'b0, trc_pkg::ADR_ISTAT, 32'h0);
      chk("istat", 32'h3, rdv);
      repeat (2) @(posedge sys_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wb(1'b1, trc_pkg::ADR_IMASK, 32'h0);
      ev(16'ha000, 16'h0000, 8'h00, 17'h0, 1'b1, 3'b001);
      chk("irq masked", 32'h0, {31'h0, irq});
      wb(1'b0, trc_pkg::ADR_ISTAT, 32'h0);
      chk("istat masked", 32'h3, rdv);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      testReset();
      testExec();
      testXfer();
      testCapacity();
      testFreeze();
      testIrq();
      stopTest();
   end
endmodule // tb
